// >>> design/ptm_defs.svh
// register offsets, field positions and reset values for the pin table mapper
`ifndef PTM_DEFS_SVH
`define PTM_DEFS_SVH
`define PTM_OFS_PIN4 8'hE4
`define PTM_OFS_PIN5 8'hE5
`define PTM_OFS_PIN6 8'hE6
`define PTM_OFS_PIN7 8'hE7
`define PTM_OFS_PIN8 8'hE8
`define PTM_OFS_PIN9 8'hE9
`define PTM_OFS_PIN10 8'hEA
`define PTM_OFS_PIN11 8'hEB
`define PTM_IDX_MSB 6
`define PTM_ROLE_BIT 7
`define PTM_MAP_RESET 8'h00
`define PTM_SYNC_STAGES 2
`endif

// >>> design/ptm_mapper.sv
// pin table mapper top: map registers, control table and status table routing
`timescale 1ns/10ps
`include "ptm_defs.svh"
module ptm_mapper #(
  parameter int NUM_PINS = 8,
  parameter int TABLE_BITS = 128
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // configuration port
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire ptm_pkg::ptm_addr_t cfg_addr,
  input wire ptm_pkg::ptm_reg_t cfg_wdata,
  output ptm_pkg::ptm_reg_t cfg_rdata,
  output logic cfg_hit,
  // internal tables
  input wire logic [TABLE_BITS-1:0] status_table,
  output logic [TABLE_BITS-1:0] control_table,
  // pins 4 to 11
  input wire logic [NUM_PINS-1:0] gp_pin_in,
  output logic [NUM_PINS-1:0] gp_pin_out,
  output logic [NUM_PINS-1:0] gp_pin_oe_n
);
  import ptm_pkg::*;

  // width of a table index as the map field carries it
  localparam int INDEX_BITS = `PTM_IDX_MSB + 1;

  // parameter checks: the register map fixes the pin count
  if (NUM_PINS != 8) begin : g_bad_pins
    $error("ptm_mapper serves exactly 8 pins");
  end

  // the tables must match what a seven-bit index can reach
  if (TABLE_BITS != 128) begin : g_bad_table
    $error("ptm_mapper needs 128-entry tables");
  end

  // every index value must land on a real entry, and every entry must be reachable
  if ((1 << INDEX_BITS) != TABLE_BITS) begin : g_bad_index
    $error("ptm_mapper index field must cover the table exactly");
  end

  // the pin level crosses in from the board, so two stages are the minimum
  if (`PTM_SYNC_STAGES < 2) begin : g_bad_sync
    $error("ptm_mapper needs at least two synchroniser stages");
  end

  // per pin state seen from the slices
  ptm_reg_t map_r [NUM_PINS];
  logic [NUM_PINS-1:0] level_sync;
  logic [NUM_PINS-1:0] role_status;
  logic [NUM_PINS-1:0] pin_unused;
  logic [NUM_PINS-1:0] pin_feeds_control;
  ptm_index_t bit_index [NUM_PINS];

  // configuration port decode and read path
  logic [NUM_PINS-1:0] addr_sel;
  logic [NUM_PINS-1:0] wr_sel;
  ptm_reg_t rd_mux;
  ptm_reg_t cfg_rdata_r;

  // control table storage and its next value
  logic [TABLE_BITS-1:0] control_table_r;
  logic [TABLE_BITS-1:0] control_table_nxt;

  // address decode: one select line per map register, none outside the block.
  // each register has its own offset, so at most one line is ever high
  always_comb begin
    addr_sel = '0;
    unique case (cfg_addr)
      `PTM_OFS_PIN4: addr_sel[0] = 1'b1;
      `PTM_OFS_PIN5: addr_sel[1] = 1'b1;
      `PTM_OFS_PIN6: addr_sel[2] = 1'b1;
      `PTM_OFS_PIN7: addr_sel[3] = 1'b1;
      `PTM_OFS_PIN8: addr_sel[4] = 1'b1;
      `PTM_OFS_PIN9: addr_sel[5] = 1'b1;
      `PTM_OFS_PIN10: addr_sel[6] = 1'b1;
      `PTM_OFS_PIN11: addr_sel[7] = 1'b1;
      default: addr_sel = '0; // other registers of the device live elsewhere
    endcase
  end

  // hit flag and write selects; writes outside the map range touch nothing
  assign cfg_hit = |addr_sel;
  assign wr_sel = cfg_wr ? addr_sel : '0;

  // per pin slice and field decode.
  // the slice owns the map register, the input synchroniser and the pin drive;
  // this loop only splits the map value into its two fields, flags unused pins and
  // pins that feed the control table, and picks the status entry that an output pin shows
  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
    logic status_bit;

    // field views of this pin's map register
    assign bit_index[p] = map_r[p][`PTM_IDX_MSB:0];
    assign role_status[p] = map_r[p][`PTM_ROLE_BIT];

    // the reset value marks the pin unused: it neither drives nor writes
    assign pin_unused[p] = (map_r[p] == `PTM_MAP_RESET);

    // only a used input pin may write into the control table
    assign pin_feeds_control[p] = !role_status[p] && !pin_unused[p];

    // the status entry this pin shows when it is an output
    assign status_bit = status_table[bit_index[p]];

    ptm_pin_slice u_slice (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .wr_en(wr_sel[p]),
      .wr_data(cfg_wdata),
      .map_r(map_r[p]),
      .pin_level_sync(level_sync[p]),
      .pin_in(gp_pin_in[p]),
      .status_bit(status_bit),
      .pin_out(gp_pin_out[p]),
      .pin_oe_n(gp_pin_oe_n[p])
    );
  end

  // control table next value.
  // entries no pin addresses keep their last value. when two input pins name
  // the same entry the later loop pass wins, so the higher pin number decides;
  // software should avoid such a clash, since the lower pin is then ignored
  always_comb begin
    control_table_nxt = control_table_r;
    for (int p = 0; p < NUM_PINS; p++) begin
      if (pin_feeds_control[p]) begin
        control_table_nxt[bit_index[p]] = level_sync[p];
      end
    end
  end

  // control table register, cleared at reset
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      control_table_r <= '0;
    end else begin
      control_table_r <= control_table_nxt;
    end
  end

  // the table leaves the block straight from its flip-flops
  assign control_table = control_table_r;

  // read mux over the map registers, zero for addresses outside the block.
  // a limitation: entry 0 of the control table cannot be fed by a pin, since
  // role 0 with index 0 is the same value as the unused reset state
  always_comb begin
    rd_mux = 8'h00;
    for (int p = 0; p < NUM_PINS; p++) begin
      if (addr_sel[p]) begin
        rd_mux = map_r[p];
      end
    end
  end

  // registered read data, held until the next read.
  // a read in the same cycle as a write to that register returns the old value,
  // because the mux sees the map register before the write edge lands
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cfg_rdata_r <= 8'h00;
    end else if (cfg_rd) begin
      cfg_rdata_r <= rd_mux;
    end
  end

  // read data leaves the block from its flip-flop
  assign cfg_rdata = cfg_rdata_r;

  // timing seen at the pins, for users of the block:
  // an output pin follows its status entry one edge later;
  // an input pin reaches its control entry three edges after it changes,
  // two for the synchroniser and one for the table register;
  // a new map value takes effect on the edge after the write
endmodule : ptm_mapper

// >>> design/ptm_pin_slice.sv
// one pin: map register, input synchroniser and pin drive
`timescale 1ns/10ps
`include "ptm_defs.svh"
module ptm_pin_slice (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // register write
  input wire logic wr_en,
  input wire ptm_pkg::ptm_reg_t wr_data,
  // state
  output ptm_pkg::ptm_reg_t map_r,
  output logic pin_level_sync,
  // pin
  input wire logic pin_in,
  input wire logic status_bit,
  output logic pin_out,
  output logic pin_oe_n
);
  import ptm_pkg::*;

  logic [`PTM_SYNC_STAGES-1:0] sync_r;
  logic pin_out_r;
  logic pin_oe_n_r;
  logic role_status;

  assign role_status = map_r[`PTM_ROLE_BIT];

  // map register, cleared to unused at reset
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      map_r <= `PTM_MAP_RESET;
    end else if (wr_en) begin
      map_r <= wr_data;
    end
  end

  // two-flop synchroniser for the pin level
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sync_r <= '0;
    end else begin
      sync_r <= {sync_r[`PTM_SYNC_STAGES-2:0], pin_in};
    end
  end
  assign pin_level_sync = sync_r[`PTM_SYNC_STAGES-1];

  // pin drive: status role drives continuously, control role releases the pin
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pin_out_r <= 1'b0;
      pin_oe_n_r <= 1'b1;
    end else begin
      pin_out_r <= role_status ? status_bit : 1'b0;
      pin_oe_n_r <= ~role_status;
    end
  end
  assign pin_out = pin_out_r;
  assign pin_oe_n = pin_oe_n_r;
endmodule : ptm_pin_slice

// >>> design/ptm_pkg.sv
// types shared by the pin table mapper
`include "ptm_defs.svh"
package ptm_pkg;
  typedef logic [7:0] ptm_reg_t;
  typedef logic [7:0] ptm_addr_t;
  typedef logic [`PTM_IDX_MSB:0] ptm_index_t;
  typedef enum logic {PTM_ROLE_CONTROL, PTM_ROLE_STATUS} ptm_role_e;
endpackage : ptm_pkg

// >>> test/ptm_board.sv
// board logic on the pins
`timescale 1ns/10ps
module ptm_board (
  // device
  input wire logic [7:0] gp_pin_out,
  input wire logic [7:0] gp_pin_oe_n,
  // board
  input wire logic [7:0] lvl,
  output logic [7:0] gp_pin_in
);
  // device wins where it drives, board level elsewhere
  assign gp_pin_in = (~gp_pin_oe_n & gp_pin_out) | (gp_pin_oe_n & lvl);
endmodule : ptm_board

// >>> test/ptm_mapper_assertions.sv
// pin mapper port checks
`timescale 1ns/10ps
module ptm_chk #(parameter int NUM_PINS = 8, parameter int TABLE_BITS = 128) (
  // register port
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  input wire logic [7:0] cfg_rdata,
  // tables
  input wire logic [TABLE_BITS-1:0] status_table,
  input wire logic [TABLE_BITS-1:0] control_table,
  // pins
  input wire logic [NUM_PINS-1:0] gp_pin_out,
  input wire logic [NUM_PINS-1:0] gp_pin_oe_n
);
  logic [7:0] m_r;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // shadow of the pin 4 map
  always_ff @(posedge clk_sys) begin
    if (sys_rst) m_r <= 8'h00;
    else if (cfg_wr && cfg_addr == 8'hE4) m_r <= cfg_wdata;
  end
  chk_pin_role: assert property (gp_pin_oe_n[0] == !$past(m_r[7])) else $error("role");
  chk_pin_quiet: assert property (!(gp_pin_out & gp_pin_oe_n)) else $error("quiet");
  chk_reset_idle: assert property ($past(sys_rst) |-> &gp_pin_oe_n) else $error("idle");
  chk_reset_clear: assert property ($past(sys_rst) |-> (control_table == '0) && (cfg_rdata == 8'h00))
    else $error("reset clear");
  chk_out_follow: assert property ($past(m_r[7]) |-> gp_pin_out[0] == $past(status_table[m_r[6:0]]))
    else $error("status follow");
  cover property (!gp_pin_oe_n[0]);
  cover property (cfg_rd);
  cover property (cfg_wr);
endmodule : ptm_chk
bind ptm_mapper ptm_chk #(.NUM_PINS(NUM_PINS), .TABLE_BITS(TABLE_BITS)) u_chk (.*);

// >>> test/testbench.sv
// pin mapper bench
`timescale 1ns/10ps
module testbench;
  logic clk_sys = '0, sys_rst = '1, cfg_wr = '0, cfg_rd = '0, cfg_hit;
  logic [7:0] cfg_addr = '0, cfg_wdata = '0, cfg_rdata, gp_pin_in, gp_pin_out, gp_pin_oe_n, lvl = '0;
  logic [127:0] status_table = '0, control_table;
  int n_mismatch = 0, checks = 0;
  ptm_mapper u_dut (.*);
  ptm_board u_board (.*);
  // clock
  always #5 clk_sys = ~clk_sys;
  task chk(input logic [7:0] g, e);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %0t %h %h", $time, g, e);
    end
  endtask : chk
  task acc(input logic w, logic [7:0] a, d);
    @(posedge clk_sys);
    {cfg_wr, cfg_rd, cfg_addr, cfg_wdata} <= {w, !w, a, d};
    @(posedge clk_sys);
    {cfg_wr, cfg_rd} <= 2'h0;
    #1 chk({7'h00, cfg_hit}, {7'h00, (a >= 8'hE4) && (a <= 8'hEB)});
    if (!w) chk(cfg_rdata, d);
  endtask : acc
  task complete_run;
    if (n_mismatch == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  // watchdog
  initial begin
    #20000 n_mismatch++;
    complete_run;
  end
  // reset, then register and pin tests
  initial begin
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    #1 chk(gp_pin_oe_n, 8'hFF);
    for (logic [7:0] i = 0; i < 8; i++) acc(1'b0, 8'hE4 + i, 8'h00);
    for (logic [7:0] i = 0; i < 8; i++) acc(1'b1, 8'hE4 + i, {~i[0], 7'h78} + i);
    for (logic [7:0] i = 0; i < 8; i++) acc(1'b0, 8'hE4 + i, {~i[0], 7'h78} + i);
    acc(1'b0, 8'hEC, 8'h00);
    @(posedge clk_sys) {status_table[127:120], lvl} <= 16'hC5FF;
    repeat (4) @(posedge clk_sys);
    #1 chk(gp_pin_oe_n, 8'hAA);
    chk(gp_pin_out, 8'h45);
    chk(control_table[127:120], 8'hAA);
    acc(1'b1, 8'hE4, 8'h00);
    repeat (4) @(posedge clk_sys);
    #1 chk(gp_pin_oe_n, 8'hAB);
    chk(gp_pin_out, 8'h44);
    chk(control_table[7:0], 8'h00);
    complete_run;
  end
endmodule : testbench
